// ### shared/lss_consts.svh
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH

// Link build: two lanes, 16-byte core attach word
`define LSS_LANES 2
`define LSS_CORE_BYTES 16
`define LSS_CORE_W 128
`define LSS_BEAT_W 64
`define LSS_WORD_W 32
`define LSS_UNITS 4
`define LSS_FIFO_DEPTH 4
`define LSS_HCNT_W 4
`define LSS_SCNT_W 8

// Striping unit and core width multiple by lane count
`define LSS_UNIT_WIDE 4
`define LSS_UNIT_NARROW 1
`define LSS_LANES_WIDE_MAX 2
`define LSS_MULT_LOW 4
`define LSS_MULT_HIGH 8
`define LSS_LANES_FULL 16
`define LSS_LANES_MAX 256

// Scrambler: 23-bit LFSR, feedback taps X^23+X^21+X^16+X^8+X^5+X^2+1
`define LSS_SCR_W 23
`define LSS_SCR_TAPS 23'h50_8092
`define LSS_SEED_COUNT 8
`define LSS_SEED_0 23'h1D_BFBC
`define LSS_SEED_1 23'h06_07BB
`define LSS_SEED_2 23'h1E_C760
`define LSS_SEED_3 23'h18_C0DB
`define LSS_SEED_4 23'h01_0F12
`define LSS_SEED_5 23'h19_CFC9
`define LSS_SEED_6 23'h02_77CE
`define LSS_SEED_7 23'h1B_B807

// Training and control sequence words
`define LSS_DET_HDR_WORD 32'h0000_FFFF
`define LSS_DET_SET_WORD0 32'h3C3C_3C3C
`define LSS_ZERO_WORD 32'h0000_0000
`define LSS_CLKCOMP_WORD 32'h6666_6666

`endif

// ### shared/lss_pkg.sv
`include "lss_consts.svh"
`default_nettype none
package lss_pkg;
  typedef logic [`LSS_CORE_W-1:0] lss_word_t;
  typedef logic [`LSS_BEAT_W-1:0] lss_beat_t;
  typedef logic [`LSS_SCR_W-1:0] lss_lfsr_t;
  typedef struct packed {
    lss_lfsr_t state;
    lss_beat_t data;
  } lss_scr_t;
  typedef enum logic [1:0] {LSS_LINK_DOWN, LSS_LINK_DETECT, LSS_LINK_TRAIN, LSS_LINK_UP} lss_link_t;
  typedef enum logic [2:0] {LSS_SEQ_NONE, LSS_SEQ_DET_HDR, LSS_SEQ_DET_SET, LSS_SEQ_CLKCOMP,
                            LSS_SEQ_DATA} lss_seq_t;
  typedef enum logic [2:0] {LSS_TX_OFF, LSS_TX_HDR, LSS_TX_SET, LSS_TX_UP, LSS_TX_CTRL} lss_tx_t;
endpackage
`default_nettype wire

// ### sim/lane_striping_signal_detect_bench.sv
`include "lss_consts.svh"
`default_nettype none
module lane_striping_signal_detect_bench
  import lss_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam lss_beat_t hdr_beat = {2{`LSS_DET_HDR_WORD}};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  lss_link_t link = LSS_LINK_DOWN;
  logic lc_en = 1'b0;
  logic [`LSS_HCNT_W-1:0] hcnt = 4'h1;
  logic [`LSS_SCNT_W-1:0] scnt = 8'h03;
  logic cc_req = 1'b0;
  logic [`LSS_WORD_W-1:0] cc_arg = 32'h0000_0000;
  logic tx_v = 1'b0;
  lss_word_t tx_d = '0;
  logic slow = 1'b0;
  logic cc_ack, tx_r, ltc, ltv, ltr, lrc, lrv, rxv;
  lss_word_t rx_d;
  lss_beat_t l0, l1, r0, r1;
  logic [`LSS_LANES-1:0] dh, ds;
  lss_word_t exp_q[$];
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int run = 0;
  int hdr_seen = 0;
  int set_seen = 0;
  int cc_beats = 0;
  int up_cyc = 0;
  int acks = 0;
  logic [31:0] seed = 32'h0001_7083;

  always #5 clock = ~clock;

  lss_top dut (.clock(clock), .nrst(nrst), .link_state(link), .line_coding_en(lc_en),
    .detect_header_count(hcnt), .detect_set_count(scnt), .ctrl_insert_req(cc_req),
    .ctrl_insert_arg(cc_arg), .ctrl_insert_ack(cc_ack), .core_tx_valid(tx_v),
    .core_tx_ready(tx_r), .core_tx_data(tx_d), .lane0_tx_data(l0), .lane1_tx_data(l1),
    .lane_tx_ctrl(ltc), .lane_tx_valid(ltv), .lane_tx_ready(ltr), .lane0_rx_data(r0),
    .lane1_rx_data(r1), .lane_rx_ctrl(lrc), .lane_rx_valid(lrv), .core_rx_data(rx_d),
    .core_rx_valid(rxv), .rx_detect_header(dh), .rx_detect_set(ds));
  lss_lane_model lanes (.clock(clock), .nrst(nrst), .slow(slow), .tx0(l0), .tx1(l1),
    .tx_ctrl(ltc), .tx_valid(ltv), .tx_ready(ltr), .rx0(r0), .rx1(r1), .rx_ctrl(lrc),
    .rx_valid(lrv));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic lss_word_t rnd_word();
    return {rnd(), rnd(), rnd(), rnd()};
  endfunction
  function automatic lss_beat_t cc_beat(input logic [31:0] a);
    return {a, `LSS_CLKCOMP_WORD};
  endfunction

  task automatic check(input lss_word_t got, input lss_word_t want);
    compares++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic push(input lss_word_t w);
    int n;
    n = 0;
    @(negedge clock);
    tx_v = 1'b1;
    tx_d = w;
    while (tx_r !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check(n < 400, 1'b1);
    @(posedge clock);
    exp_q.push_back(w);
  endtask
  task automatic drain();
    int n;
    n = 0;
    @(negedge clock);
    tx_v = 1'b0;
    while (exp_q.size() != 0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check(exp_q.size(), 0);
    repeat (10) @(negedge clock);
  endtask

  // Wire and core-side monitor
  always @(posedge clock) begin
    cyc++;
    up_cyc = (link == LSS_LINK_UP) ? up_cyc + 1 : 0;
    if (link == LSS_LINK_TRAIN) check(ltv, 1'b0);
    if (ltv && ltr) begin
      if (l0 === hdr_beat) begin
        run++;
        check(ltc, 1'b1);
        check(l1, l0);
      end else begin
        if (run > 0 && link == LSS_LINK_DETECT) check(run, 2 * hcnt);
        run = 0;
      end
      if (up_cyc > 10 && ltc) begin
        cc_beats++;
        check(l0, cc_beat(cc_arg));
        check(l1, l0);
        check(lc_en, 1'b1);
      end
    end
    if (rxv) begin
      check(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0) check(rx_d, exp_q.pop_front());
    end
    if (cc_ack === 1'b1) acks++;
    if (dh != 0) hdr_seen++;
    if (ds != 0) set_seen++;
    if (cyc > 20000) begin
      failures++;
      summarize();
    end
  end
  always @(negedge clock) if (cc_ack === 1'b1) cc_req <= 1'b0;

  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    link = LSS_LINK_TRAIN;
    for (int i = 0; i < 4; i++) push(rnd_word());
    @(negedge clock);
    tx_v = 1'b0;
    check(tx_r, 1'b0);
    $display("test training hold done");
    for (int r = 0; r < 2; r++) begin
      hcnt = 4'(2 * r + 1);
      slow = rnd() & 32'h0000_0001;
      hdr_seen = 0;
      set_seen = 0;
      link = LSS_LINK_DETECT;
      repeat (120) @(negedge clock);
      check(hdr_seen > 0, 1'b1);
      check(set_seen > 0, 1'b1);
      $display("test detect round %0d done", r);
      link = LSS_LINK_UP;
      lc_en = 1'b1;
      cc_arg = rnd();
      cc_beats = 0;
      acks = 0;
      repeat (10) @(negedge clock);
      cc_req = 1'b1;
      for (int i = 0; i < 12; i++) push(rnd_word());
      drain();
      check(cc_beats >= 2, 1'b1);
      check(acks, 1);
      lc_en = 1'b0;
      cc_req = 1'b1;
      for (int i = 0; i < 6; i++) push(rnd_word());
      drain();
      check(acks, 1);
      cc_req = 1'b0;
      $display("test operational round %0d done", r);
    end
    link = LSS_LINK_DOWN;
    repeat (4) @(negedge clock);
    summarize();
  end
endmodule
`default_nettype wire

// ### sim/lss_lane_model.sv
`default_nettype none
module lss_lane_model
  import lss_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  input wire lss_beat_t tx0,
  input wire lss_beat_t tx1,
  input wire logic tx_ctrl,
  input wire logic tx_valid,
  output logic tx_ready,
  output lss_beat_t rx0,
  output lss_beat_t rx1,
  output logic rx_ctrl,
  output logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // Serializer stalls three cycles in four when slow
  assign tx_ready = !slow || cnt == 2'd0;
  // Far port echoes only the beats it was handed; idle lanes toggle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 2'd0;
      rx0 <= '0;
      rx1 <= '0;
      rx_ctrl <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      cnt <= cnt + 2'd1;
      rx_valid <= tx_valid && tx_ready;
      rx0 <= (tx_valid && tx_ready) ? tx0 : ~rx0;
      rx1 <= (tx_valid && tx_ready) ? tx1 : ~rx1;
      rx_ctrl <= (tx_valid && tx_ready) ? tx_ctrl : ~rx_ctrl;
    end
  end
endmodule
`default_nettype wire

// ### verilog/lss_fifo.sv
`include "lss_consts.svh"
`default_nettype none
module lss_fifo
  import lss_pkg::*;
#(
  parameter int WIDTH = `LSS_CORE_W,
  parameter int DEPTH = `LSS_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] lss_ptr_inc(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : p + AW'(1);
  endfunction

  assign in_ready = count != FULL;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= lss_ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= lss_ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + (AW+1)'(1);
      end else if (pop && !push) begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/lss_top.sv
// Summary of operation
// RULE1: Stripe every core data word across lanes before scrambling; receiver undoes striping.
// RULE2: Control sequences bypass striping and go identically on all lanes together.
// RULE3: One or two lanes stripe 4-byte units; four to 256 lanes stripe bytes.
// RULE4: Two lanes take successive 4-byte units alternately, lane 0 then lane 1.
// RULE5: Core word multiple is 4,8,4,8 bytes for 1,2,4,8 lanes, else lanes.
// RULE6: Core word width must be a whole multiple of that byte multiple.
// RULE7: Receiver consumes control sequences and never forwards them to the core.
// RULE8: During training only control sequences are sent, never core data.
// RULE9: With line coding, core data may stall to insert clock compensation.
// RULE10: Without line coding, operational state carries only core data.
// RULE11: Sequences are four 32-bit words; sequence type decides scrambling.
// RULE12: Detect header is four 0x0000FFFF words, sent unscrambled.
// RULE13: Detect set is scrambled, word 0 0x3C3C3C3C, words 1 to 3 zero.
// RULE14: Detect headers and sets are exchanged only in the signal-detect state.
// RULE15: Each lane receiver resets its scrambler on every received detect header.
// RULE16: Header repeat count is configurable; default one header then detect sets.
// RULE17: Scrambler is a 23-bit LFSR for X^23+X^21+X^16+X^8+X^5+X^2+1.
// RULE18: Unscrambled sequences bypass the scrambler, which holds without advancing.
// RULE19: Lane scrambler seed is chosen by lane number modulo 8.
// RULE20: Header recognised only when all four received words match exactly.
// RULE21: Lane count and width fixed at build; receive reassembles in transmit order.
`include "lss_consts.svh"
`default_nettype none
module lss_top
  import lss_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire lss_link_t link_state,
  input wire logic line_coding_en,
  input wire logic [`LSS_HCNT_W-1:0] detect_header_count,
  input wire logic [`LSS_SCNT_W-1:0] detect_set_count,
  input wire logic ctrl_insert_req,
  input wire logic [`LSS_WORD_W-1:0] ctrl_insert_arg,
  output logic ctrl_insert_ack,
  input wire logic core_tx_valid,
  output logic core_tx_ready,
  input wire logic [`LSS_CORE_W-1:0] core_tx_data,
  output logic [`LSS_BEAT_W-1:0] lane0_tx_data,
  output logic [`LSS_BEAT_W-1:0] lane1_tx_data,
  output logic lane_tx_ctrl,
  output logic lane_tx_valid,
  input wire logic lane_tx_ready,
  input wire logic [`LSS_BEAT_W-1:0] lane0_rx_data,
  input wire logic [`LSS_BEAT_W-1:0] lane1_rx_data,
  input wire logic lane_rx_ctrl,
  input wire logic lane_rx_valid,
  output logic [`LSS_CORE_W-1:0] core_rx_data,
  output logic core_rx_valid,
  output logic [`LSS_LANES-1:0] rx_detect_header,
  output logic [`LSS_LANES-1:0] rx_detect_set
);
  localparam lss_beat_t HDR_BEAT = {`LSS_DET_HDR_WORD, `LSS_DET_HDR_WORD};
  localparam lss_beat_t SET_BEAT0 = {`LSS_ZERO_WORD, `LSS_DET_SET_WORD0};
  localparam lss_beat_t ZERO_BEAT = {`LSS_ZERO_WORD, `LSS_ZERO_WORD};

  // Scramble a beat LSB first, one LFSR step per bit
  function automatic lss_scr_t lss_scr64(input lss_lfsr_t seed, input lss_beat_t din);
    lss_scr_t r;
    r.state = seed;
    r.data = '0;
    for (int b = 0; b < `LSS_BEAT_W; b++) begin
      r.data[b] = din[b] ^ r.state[`LSS_SCR_W-1]; // see RULE17
      r.state = {r.state[`LSS_SCR_W-2:0], ^(r.state & `LSS_SCR_TAPS)}; // see RULE17
    end
    return r;
  endfunction

  function automatic lss_lfsr_t lss_lane_seed(input int lane);
    case (lane % `LSS_SEED_COUNT) // see RULE19
      0: return `LSS_SEED_0;
      1: return `LSS_SEED_1;
      2: return `LSS_SEED_2;
      3: return `LSS_SEED_3;
      4: return `LSS_SEED_4;
      5: return `LSS_SEED_5;
      6: return `LSS_SEED_6;
      default: return `LSS_SEED_7;
    endcase
  endfunction

  function automatic int lss_stripe_unit(input int lanes);
    return (lanes <= `LSS_LANES_WIDE_MAX) ? `LSS_UNIT_WIDE : `LSS_UNIT_NARROW; // see RULE3
  endfunction

  function automatic int lss_base_mult(input int lanes);
    if (lanes >= `LSS_LANES_FULL) begin
      return lanes; // see RULE5
    end
    // Two and eight lanes need eight-byte words, one and four lanes four
    return (lanes == `LSS_LANES_WIDE_MAX || lanes == `LSS_MULT_HIGH) ?
      `LSS_MULT_HIGH : `LSS_MULT_LOW; // see RULE5
  endfunction

  // Unit u goes to lane u mod lanes, slot u div lanes
  function automatic lss_word_t lss_stripe(input lss_word_t w);
    lss_word_t r;
    r = '0;
    for (int u = 0; u < `LSS_UNITS; u++) begin
      r[(u % `LSS_LANES) * `LSS_BEAT_W + (u / `LSS_LANES) * `LSS_WORD_W +: `LSS_WORD_W] =
        w[u * `LSS_WORD_W +: `LSS_WORD_W]; // see RULE4
    end
    return r;
  endfunction

  function automatic lss_word_t lss_destripe(input lss_word_t s);
    lss_word_t r;
    r = '0;
    for (int u = 0; u < `LSS_UNITS; u++) begin
      r[u * `LSS_WORD_W +: `LSS_WORD_W] =
        s[(u % `LSS_LANES) * `LSS_BEAT_W + (u / `LSS_LANES) * `LSS_WORD_W +: `LSS_WORD_W]; // see RULE21
    end
    return r;
  endfunction

  function automatic logic lss_seq_scrambled(input lss_seq_t k);
    return (k == LSS_SEQ_DET_SET) || (k == LSS_SEQ_DATA); // see RULE11
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Transmit path
  logic fifo_out_valid;
  logic fifo_pop;
  lss_word_t fifo_out_data;
  lss_word_t striped;
  lss_tx_t tx_state;
  lss_tx_t next_state;
  lss_seq_t tx_kind;
  lss_seq_t next_kind;
  logic tx_beat;
  logic next_beat;
  logic [`LSS_HCNT_W-1:0] hdr_cnt;
  logic [`LSS_HCNT_W-1:0] next_hdr_cnt;
  logic [`LSS_HCNT_W-1:0] hdr_limit;
  logic [`LSS_SCNT_W-1:0] set_cnt;
  logic [`LSS_SCNT_W-1:0] next_set_cnt;
  logic [`LSS_SCNT_W-1:0] set_limit;
  lss_lfsr_t tx_scr0;
  lss_lfsr_t tx_scr1;
  lss_beat_t raw0;
  lss_beat_t raw1;
  lss_scr_t sc0;
  lss_scr_t sc1;
  logic seed_load;
  logic ack_set;
  logic tx_adv;

  lss_fifo #(
    .WIDTH(`LSS_CORE_W),
    .DEPTH(`LSS_FIFO_DEPTH)
  ) u_tx_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(core_tx_valid),
    .in_ready(core_tx_ready),
    .in_data(core_tx_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign tx_adv = !lane_tx_valid || lane_tx_ready;
  assign striped = lss_stripe(fifo_out_data); // see RULE1
  // A zero count still sends one header
  assign hdr_limit = (detect_header_count == '0) ? `LSS_HCNT_W'(1) : detect_header_count; // see RULE16
  assign set_limit = (detect_set_count == '0) ? `LSS_SCNT_W'(1) : detect_set_count;

  always_comb begin
    next_state = tx_state;
    next_beat = tx_beat;
    next_hdr_cnt = hdr_cnt;
    next_set_cnt = set_cnt;
    next_kind = LSS_SEQ_NONE;
    raw0 = '0;
    raw1 = '0;
    fifo_pop = 1'b0;
    seed_load = 1'b0;
    ack_set = 1'b0;
    if (tx_adv) begin
      case (tx_state)
        LSS_TX_OFF: begin
          if (link_state == LSS_LINK_DETECT) begin
            next_state = LSS_TX_HDR;
            next_beat = 1'b0;
            next_hdr_cnt = '0;
            next_set_cnt = '0;
            seed_load = 1'b1;
          end else if (link_state == LSS_LINK_UP) begin
            next_state = LSS_TX_UP;
          end
        end
        LSS_TX_HDR: begin
          if (link_state != LSS_LINK_DETECT && !tx_beat) begin
            next_state = LSS_TX_OFF; // see RULE14
          end else begin
            next_kind = LSS_SEQ_DET_HDR;
            raw0 = HDR_BEAT; // see RULE12
            raw1 = HDR_BEAT; // see RULE2
            next_beat = !tx_beat;
            if (tx_beat) begin
              if (hdr_cnt + `LSS_HCNT_W'(1) >= hdr_limit) begin
                next_state = LSS_TX_SET; // see RULE16
                next_hdr_cnt = '0;
                seed_load = 1'b1;
              end else begin
                next_hdr_cnt = hdr_cnt + `LSS_HCNT_W'(1);
              end
            end
          end
        end
        LSS_TX_SET: begin
          if (link_state != LSS_LINK_DETECT && !tx_beat) begin
            next_state = LSS_TX_OFF; // see RULE14
          end else begin
            next_kind = LSS_SEQ_DET_SET;
            raw0 = tx_beat ? ZERO_BEAT : SET_BEAT0; // see RULE13
            raw1 = raw0;
            next_beat = !tx_beat;
            if (tx_beat) begin
              if (set_cnt + `LSS_SCNT_W'(1) >= set_limit) begin
                next_state = LSS_TX_HDR;
                next_set_cnt = '0;
              end else begin
                next_set_cnt = set_cnt + `LSS_SCNT_W'(1);
              end
            end
          end
        end
        LSS_TX_UP: begin
          if (link_state != LSS_LINK_UP) begin
            next_state = LSS_TX_OFF; // see RULE8
          end else if (ctrl_insert_req && line_coding_en) begin
            next_kind = LSS_SEQ_CLKCOMP; // see RULE9
            raw0 = {ctrl_insert_arg, `LSS_CLKCOMP_WORD};
            raw1 = raw0; // see RULE2
            next_state = LSS_TX_CTRL;
          end else if (fifo_out_valid) begin
            next_kind = LSS_SEQ_DATA; // see RULE10
            raw0 = striped[`LSS_BEAT_W-1:0];
            raw1 = striped[`LSS_CORE_W-1:`LSS_BEAT_W];
            fifo_pop = 1'b1;
          end
        end
        LSS_TX_CTRL: begin
          next_kind = LSS_SEQ_CLKCOMP;
          raw0 = {ctrl_insert_arg, `LSS_CLKCOMP_WORD};
          raw1 = raw0;
          next_state = LSS_TX_UP;
          ack_set = 1'b1;
        end
        default: begin
          next_state = LSS_TX_OFF;
        end
      endcase
    end
  end

  assign sc0 = lss_scr64(tx_scr0, raw0);
  assign sc1 = lss_scr64(tx_scr1, raw1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_state <= LSS_TX_OFF;
      tx_beat <= 1'b0;
      hdr_cnt <= '0;
      set_cnt <= '0;
      ctrl_insert_ack <= 1'b0;
    end else begin
      tx_state <= next_state;
      tx_beat <= next_beat;
      hdr_cnt <= next_hdr_cnt;
      set_cnt <= next_set_cnt;
      ctrl_insert_ack <= ack_set;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_scr0 <= `LSS_SEED_0;
      tx_scr1 <= `LSS_SEED_1;
    end else if (seed_load) begin
      tx_scr0 <= lss_lane_seed(0); // see RULE19
      tx_scr1 <= lss_lane_seed(1);
    end else if (lss_seq_scrambled(next_kind)) begin
      tx_scr0 <= sc0.state;
      tx_scr1 <= sc1.state;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lane0_tx_data <= '0;
      lane1_tx_data <= '0;
      lane_tx_ctrl <= 1'b0;
      lane_tx_valid <= 1'b0;
      tx_kind <= LSS_SEQ_NONE;
    end else if (tx_adv) begin
      // Unscrambled kinds bypass the LFSR output
      lane0_tx_data <= lss_seq_scrambled(next_kind) ? sc0.data : raw0; // see RULE18
      lane1_tx_data <= lss_seq_scrambled(next_kind) ? sc1.data : raw1;
      lane_tx_ctrl <= next_kind != LSS_SEQ_DATA;
      lane_tx_valid <= next_kind != LSS_SEQ_NONE;
      tx_kind <= next_kind;
    end
  end

  // Receive path
  lss_beat_t rx_in [`LSS_LANES];
  lss_lfsr_t rx_scr [`LSS_LANES];
  lss_scr_t rx_dsc [`LSS_LANES];
  logic [`LSS_LANES-1:0] rx_hdr_half;
  logic [`LSS_LANES-1:0] rx_phase;

  assign rx_in[0] = lane0_rx_data;
  assign rx_in[1] = lane1_rx_data;

  always_comb begin
    for (int i = 0; i < `LSS_LANES; i++) begin
      rx_dsc[i] = lss_scr64(rx_scr[i], rx_in[i]);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_scr[0] <= `LSS_SEED_0;
      rx_scr[1] <= `LSS_SEED_1;
      rx_hdr_half <= '0;
      rx_phase <= '0;
      rx_detect_header <= '0;
      rx_detect_set <= '0;
    end else begin
      rx_detect_header <= '0;
      rx_detect_set <= '0;
      for (int i = 0; i < `LSS_LANES; i++) begin
        if (!lane_rx_valid) begin
          rx_hdr_half[i] <= rx_hdr_half[i];
        end else if (link_state == LSS_LINK_DETECT ||
                     (lane_rx_ctrl && rx_in[i] == HDR_BEAT)) begin
          // Headers still in flight after detect ends keep both scramblers in step
          if (rx_in[i] == HDR_BEAT) begin
            if (rx_hdr_half[i]) begin
              rx_scr[i] <= lss_lane_seed(i); // see RULE15
              rx_phase[i] <= 1'b0;
              rx_hdr_half[i] <= 1'b0;
              rx_detect_header[i] <= 1'b1; // see RULE20
            end else begin
              rx_hdr_half[i] <= 1'b1;
            end
          end else begin
            rx_hdr_half[i] <= 1'b0;
            rx_scr[i] <= rx_dsc[i].state;
            rx_phase[i] <= !rx_phase[i];
            if (!rx_phase[i] && rx_dsc[i].data == SET_BEAT0) begin
              rx_detect_set[i] <= 1'b1; // see RULE14
            end
          end
        end else if (link_state == LSS_LINK_UP) begin
          rx_hdr_half[i] <= 1'b0;
          if (!(lane_rx_ctrl && rx_in[i][`LSS_WORD_W-1:0] == `LSS_CLKCOMP_WORD)) begin
            rx_scr[i] <= rx_dsc[i].state; // see RULE18
          end
        end else begin
          rx_hdr_half[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_rx_valid <= 1'b0;
      core_rx_data <= '0;
    end else begin
      core_rx_valid <= lane_rx_valid && link_state == LSS_LINK_UP && !lane_rx_ctrl; // see RULE7
      if (lane_rx_valid && link_state == LSS_LINK_UP && !lane_rx_ctrl) begin
        core_rx_data <= lss_destripe({rx_dsc[1].data, rx_dsc[0].data}); // see RULE1
      end
    end
  end

  sequence s_last_hdr;
    tx_adv && tx_state == LSS_TX_HDR && tx_beat && next_state == LSS_TX_SET;
  endsequence

  sequence s_hdr_out;
    lane_tx_valid && tx_kind == LSS_SEQ_DET_HDR;
  endsequence

  a_width_multiple: assert property (`LSS_CORE_BYTES % lss_base_mult(`LSS_LANES) == 0) // see RULE6
    else $error("core width not a multiple of lane byte multiple");
  a_stripe_unit: assert property (lss_stripe_unit(`LSS_LANES) * `LSS_UNITS == `LSS_CORE_BYTES) // see RULE3
    else $error("striping unit does not match lane count");
  a_stripe_round: assert property (fifo_out_valid |-> lss_destripe(striped) == fifo_out_data) // see RULE21
    else $error("destripe does not invert stripe");
  a_hdr_pattern: assert property (s_hdr_out |-> lane0_tx_data == HDR_BEAT && lane1_tx_data == HDR_BEAT) // see RULE12
    else $error("detect header beat wrong");
  a_seed_after_hdr: assert property (s_last_hdr |=> tx_scr0 == `LSS_SEED_0 && tx_scr1 == `LSS_SEED_1) // see RULE19
    else $error("scrambler not reseeded after last header");
  a_hdr_scr_hold: assert property (tx_adv && next_kind == LSS_SEQ_DET_HDR && !tx_beat |=> $stable(tx_scr0)) // see RULE18
    else $error("scrambler advanced on header");
  a_data_only_up: assert property (tx_adv && next_kind == LSS_SEQ_DATA |-> link_state == LSS_LINK_UP) // see RULE8
    else $error("core data sent outside operational state");
  a_stall_coded: assert property (tx_adv && tx_state == LSS_TX_UP && next_kind == LSS_SEQ_CLKCOMP |-> line_coding_en) // see RULE10
    else $error("control inserted without line coding");
  a_ctrl_not_fwd: assert property (lane_rx_valid && lane_rx_ctrl |=> !core_rx_valid) // see RULE7
    else $error("control sequence forwarded to core");
  a_rx_hdr_reset: assert property (rx_detect_header[0] |-> rx_scr[0] == `LSS_SEED_0 && $past(rx_hdr_half[0])) // see RULE15
    else $error("receive header did not reset scrambler");
endmodule
`default_nettype wire
